// file: verilog/rsi_top.sv
`timescale 1ns/1ps
module rsi_top #(
  parameter int unsigned STOP_RESP_CYC = rsi_pkg::STOP_RESP_CYC_DF
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  resetn_in,
  input  wire rsi_pkg::rsi_axi_req_t axi_req_in,
  output rsi_pkg::rsi_axi_rsp_t      axi_rsp_out,
  input  wire logic                  special_stop_in,
  input  wire logic                  estop_a_in,
  input  wire logic                  estop_b_in,
  input  wire logic                  door_a_in,
  input  wire logic                  door_b_in,
  input  wire logic                  mode_a_in,
  input  wire logic                  mode_b_in,
  input  wire logic                  pendant_en_in,
  input  wire logic                  enable_sw_in,
  output logic                       servo_on_out,
  output logic                       motion_stop_out,
  output logic                       robot_error_out,
  output logic                       estop_out,
  output logic                       mode_out,
  output logic                       jog_permit_out,
  output logic                       brake_release_out,
  output logic                       auto_permit_out,
  output logic                       irq_out
);
  import rsi_pkg::*;

  logic [PINW-1:0] pins;
  logic [PINW-1:0] pins_s;
  logic            stop_s;
  logic            pend_s;
  logic            esw_s;
  logic            est_ok;
  logic            est_open;
  logic            est_flt;
  logic            door_ok;
  logic            door_open;
  logic            door_flt;
  logic            mode_auto;
  logic            mode_man;
  logic            mode_flt;
  logic            hard_flt;
  logic            auto_ok;
  logic            man_ok;
  logic            brake_ok;
  logic            wdog_r;
  logic [15:0]     wdog_cnt_r;
  rsi_state_t      state_r;
  rsi_state_t      state_nxt;
  logic [EVW-1:0]  status_r;
  logic [EVW-1:0]  status_nxt;
  logic [EVW-1:0]  mask_r;
  logic [EVW-1:0]  ev;
  logic [EVW-1:0]  w1c;
  logic [4:0]      prev_r;
  logic            on_req;
  logic            off_req;
  logic            start_req;
  logic            alm_rst;
  logic            brake_req_r;
  logic            aw_have_r;
  logic            w_have_r;
  logic [3:0]      awaddr_r;
  logic [31:0]     wdata_r;
  logic [3:0]      wstrb_r;
  logic            wr_go;
  logic            wr_hit;
  logic [31:0]     rd_mux;
  logic            rd_hit;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; special stop owns bit PIN_STOP alone
  assign pins = {enable_sw_in, pendant_en_in, mode_b_in, mode_a_in,
                 door_b_in, door_a_in, estop_b_in, estop_a_in,
                 special_stop_in};

  rsi_sync #(.W(PINW)) u_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .d_in       (pins),
    .q_out      (pins_s)
  );

  assign stop_s = pins_s[PIN_STOP];
  assign pend_s = pins_s[PIN_PEN];
  assign esw_s  = pins_s[PIN_ESW];

  // Dual-channel contacts, closed reads as one
  rsi_dual_chk u_estop (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .a_in       (pins_s[PIN_EA]),
    .b_in       (pins_s[PIN_EB]),
    .closed_out (est_ok),
    .open_out   (est_open),
    .fault_out  (est_flt)
  );

  rsi_dual_chk u_door (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .a_in       (pins_s[PIN_DA]),
    .b_in       (pins_s[PIN_DB]),
    .closed_out (door_ok),
    .open_out   (door_open),
    .fault_out  (door_flt)
  );

  rsi_dual_chk u_mode (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .a_in       (pins_s[PIN_MA]),
    .b_in       (pins_s[PIN_MB]),
    .closed_out (mode_auto),
    .open_out   (mode_man),
    .fault_out  (mode_flt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Permit terms; a mismatch anywhere is treated as unsafe
  assign hard_flt = ~est_ok | est_flt | door_flt | mode_flt | wdog_r;
  assign auto_ok  = mode_auto & door_ok & ~pend_s & ~hard_flt;
  assign man_ok   = mode_man & pend_s & esw_s & ~hard_flt;
  assign brake_ok = mode_man & pend_s & esw_s & ~hard_flt;

  ////////////////////////////////////////////////////////////////////////
  // Stop watchdog: stop seen but motion not halted in time
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wdog_cnt_r <= 16'h0000;
      wdog_r     <= 1'b0;
    end else if (stop_s && !motion_stop_out) begin
      wdog_cnt_r <= wdog_cnt_r + 16'h0001;
      if (wdog_cnt_r >= 16'(STOP_RESP_CYC - 1)) begin
        wdog_r <= 1'b1;
      end
    end else begin
      wdog_cnt_r <= 16'h0000;
      if (alm_rst) begin
        wdog_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Servo state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: begin
        if (on_req && (auto_ok || man_ok)) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (off_req) begin
          state_nxt = ST_OFF;
        end else if (mode_auto && door_open) begin
          state_nxt = ST_ALARM;
        end else if (!(auto_ok || man_ok)) begin
          state_nxt = ST_OFF;
        end else if (start_req && auto_ok && !stop_s) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!door_ok) begin
          state_nxt = ST_ALARM;
        end else if (off_req) begin
          state_nxt = ST_OFF;
        end else if (stop_s || !auto_ok) begin
          state_nxt = ST_ON;
        end
      end
      ST_ALARM: begin
        // Leave only on reset with safety chain whole
        if (alm_rst && !hard_flt && (door_ok || mode_man)) begin
          state_nxt = ST_OFF;
        end
      end
    endcase
    if (hard_flt) begin
      state_nxt = ST_ALARM;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_ALARM;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pin outputs, derived from next state except estop_out and mode_out
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      servo_on_out      <= 1'b0;
      motion_stop_out   <= 1'b1;
      robot_error_out   <= 1'b1;
      estop_out         <= 1'b0;
      mode_out          <= 1'b0;
      jog_permit_out    <= 1'b0;
      brake_release_out <= 1'b0;
      auto_permit_out   <= 1'b0;
    end else begin
      servo_on_out      <= (state_nxt == ST_ON) || (state_nxt == ST_RUN);
      motion_stop_out   <= stop_s || (state_nxt != ST_RUN && !man_ok) ||
                           (state_nxt == ST_ALARM) || (state_nxt == ST_OFF);
      robot_error_out   <= (state_nxt == ST_ALARM);
      estop_out         <= est_ok;
      mode_out          <= mode_auto;
      jog_permit_out    <= (state_nxt == ST_ON) && man_ok && !stop_s;
      brake_release_out <= brake_req_r && brake_ok &&
                           (state_nxt == ST_OFF);
      auto_permit_out   <= (state_nxt == ST_RUN) && auto_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, sticky status; set beats a same-cycle clear
  assign ev[EV_DOOR_ERR] = (state_r == ST_RUN) && !door_ok;
  assign ev[EV_ESTOP]    = ~est_ok & ~prev_r[0];
  assign ev[EV_SSTOP]    = stop_s & ~prev_r[1];
  assign ev[EV_CHAN]     = (est_flt | door_flt) & ~prev_r[2];
  assign ev[EV_MODE]     = mode_flt & ~prev_r[3];
  assign ev[EV_WDOG]     = wdog_r & ~prev_r[4];
  assign w1c = wr_hit && awaddr_r == REG_STATUS && wstrb_r[0] ? wdata_r[EVW-1:0] : '0;
  assign status_nxt = (status_r & ~w1c) | ev;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_r   <= 5'h01;
      status_r <= '0;
      irq_out  <= 1'b0;
    end else begin
      prev_r   <= {wdog_r, mode_flt, est_flt | door_flt, stop_s, ~est_ok};
      status_r <= status_nxt;
      irq_out  <= |(status_nxt & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register: pulses self-clear, brake request is a level
  assign on_req    = wr_hit && awaddr_r == REG_CTRL && wstrb_r[0] && wdata_r[CTRL_SERVO_ON];
  assign off_req   = wr_hit && awaddr_r == REG_CTRL && wstrb_r[0] && wdata_r[CTRL_SERVO_OFF];
  assign start_req = wr_hit && awaddr_r == REG_CTRL && wstrb_r[0] && wdata_r[CTRL_START];
  assign alm_rst   = wr_hit && awaddr_r == REG_CTRL && wstrb_r[0] && wdata_r[CTRL_ALM_RST];

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brake_req_r <= 1'b0;
      mask_r      <= MASK_RST;
    end else if (wr_hit && wstrb_r[0]) begin
      if (awaddr_r == REG_CTRL) begin
        brake_req_r <= wdata_r[CTRL_BRAKE];
      end
      if (awaddr_r == REG_MASK) begin
        mask_r <= wdata_r[EVW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data in either order
  assign wr_go  = aw_have_r && w_have_r && !axi_rsp_out.bvalid;
  assign wr_hit = wr_go && (awaddr_r[1:0] == 2'h0);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_have_r           <= 1'b0;
      w_have_r            <= 1'b0;
      awaddr_r            <= 4'h0;
      wdata_r             <= 32'h00000000;
      wstrb_r             <= 4'h0;
      axi_rsp_out.awready <= 1'b0;
      axi_rsp_out.wready  <= 1'b0;
      axi_rsp_out.bvalid  <= 1'b0;
      axi_rsp_out.bresp   <= RESP_OK;
    end else begin
      axi_rsp_out.awready <= axi_req_in.awvalid && !axi_rsp_out.awready && !aw_have_r;
      axi_rsp_out.wready  <= axi_req_in.wvalid && !axi_rsp_out.wready && !w_have_r;
      if (axi_req_in.awvalid && axi_rsp_out.awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= axi_req_in.awaddr;
      end
      if (axi_req_in.wvalid && axi_rsp_out.wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= axi_req_in.wdata;
        wstrb_r  <= axi_req_in.wstrb;
      end
      if (wr_go) begin
        axi_rsp_out.bvalid <= 1'b1;
        axi_rsp_out.bresp  <= wr_hit && awaddr_r != REG_STATE ? RESP_OK : RESP_ERR;
      end else if (axi_rsp_out.bvalid && axi_req_in.bready) begin
        axi_rsp_out.bvalid <= 1'b0;
        aw_have_r          <= 1'b0;
        w_have_r           <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = axi_req_in.araddr[1:0] == 2'h0;
    unique case (axi_req_in.araddr[3:2])
      2'h0: rd_mux = {27'h0000000, brake_req_r, 4'h0};
      2'h1: rd_mux = {26'h0000000, status_r};
      2'h2: rd_mux = {26'h0000000, mask_r};
      2'h3: rd_mux = {19'h00000, auto_permit_out, brake_release_out,
                      jog_permit_out, mode_out, esw_s, pend_s, door_ok,
                      est_ok, stop_s, robot_error_out, servo_on_out,
                      state_r};
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      axi_rsp_out.arready <= 1'b0;
      axi_rsp_out.rvalid  <= 1'b0;
      axi_rsp_out.rdata   <= 32'h00000000;
      axi_rsp_out.rresp   <= RESP_OK;
    end else begin
      axi_rsp_out.arready <= axi_req_in.arvalid && !axi_rsp_out.arready && !axi_rsp_out.rvalid;
      if (axi_req_in.arvalid && axi_rsp_out.arready) begin
        axi_rsp_out.rvalid <= 1'b1;
        axi_rsp_out.rdata  <= rd_hit ? rd_mux : 32'h00000000;
        axi_rsp_out.rresp  <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (axi_rsp_out.rvalid && axi_req_in.rready) begin
        axi_rsp_out.rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_stop_response: assert property ($rose(stop_s) |=> motion_stop_out)
    else $error("special stop did not halt motion");
  a_door_trip: assert property (state_r == ST_RUN && door_open |=>
    state_r == ST_ALARM && !servo_on_out && robot_error_out)
    else $error("door open in run did not trip");
  a_alarm_hold: assert property (state_r == ST_ALARM && !alm_rst |=>
    state_r == ST_ALARM)
    else $error("alarm left without reset");
  a_teach_door: assert property (state_r == ST_OFF && on_req && man_ok &&
    door_open |=> servo_on_out)
    else $error("open door blocked teach servo on");
  a_mode_auto: assert property (mode_auto |=> mode_out)
    else $error("closed mode input not automatic");
  a_jog_gate: assert property (jog_permit_out |->
    $past(pend_s && esw_s && mode_man))
    else $error("jog permitted without conditions");
  a_auto_gate: assert property (auto_permit_out |->
    $past(!pend_s && mode_auto && door_ok))
    else $error("auto permitted without conditions");
  a_brake_gate: assert property (brake_release_out |->
    $past(pend_s && esw_s && mode_man))
    else $error("brake release without conditions");
  a_mode_open: assert property (mode_man |=> !mode_out)
    else $error("mode output closed in manual");
  a_chan_fault: assert property (door_flt || est_flt |=>
    robot_error_out [*2])
    else $error("channel mismatch without error");
  a_undef_safe: assert property (mode_flt |=> !servo_on_out)
    else $error("servo on with undefined mode");

endmodule

// file: verilog/rsi_pkg.sv
package rsi_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK   = 4'h8;
  localparam logic [3:0] REG_STATE  = 4'hC;

  // Control fields
  localparam int CTRL_SERVO_ON  = 0;
  localparam int CTRL_SERVO_OFF = 1;
  localparam int CTRL_START     = 2;
  localparam int CTRL_ALM_RST   = 3;
  localparam int CTRL_BRAKE     = 4;

  // Event bits, shared by status and mask
  localparam int EVW         = 6;
  localparam int EV_DOOR_ERR = 0;
  localparam int EV_ESTOP    = 1;
  localparam int EV_SSTOP    = 2;
  localparam int EV_CHAN     = 3;
  localparam int EV_MODE     = 4;
  localparam int EV_WDOG     = 5;

  localparam logic [EVW-1:0] MASK_RST = 6'h00;
  localparam logic [1:0]     RESP_OK  = 2'h0;
  localparam logic [1:0]     RESP_ERR = 2'h2;

  // Synchroniser bit map
  localparam int PINW     = 9;
  localparam int PIN_STOP = 0;
  localparam int PIN_EA   = 1;
  localparam int PIN_EB   = 2;
  localparam int PIN_DA   = 3;
  localparam int PIN_DB   = 4;
  localparam int PIN_MA   = 5;
  localparam int PIN_MB   = 6;
  localparam int PIN_PEN  = 7;
  localparam int PIN_ESW  = 8;

  // Timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int STOP_RESP_NS     = 1000000;
  localparam int STOP_RESP_CYC_DF = STOP_RESP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_RUN, ST_ALARM} rsi_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } rsi_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rsi_axi_rsp_t;

endpackage

// file: verilog/rsi_sync.sv
`timescale 1ns/1ps
module rsi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  ////////////////////////////////////////////////////////////////////////
  // Two flops per pin; only the second flop is read outside
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic q_r;
      always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
          meta_r <= 1'b0;
          q_r    <= 1'b0;
        end else begin
          meta_r <= d_in[i];
          q_r    <= meta_r;
        end
      end
      assign q_out[i] = q_r;
    end
  endgenerate
endmodule

// file: verilog/rsi_dual_chk.sv
`timescale 1ns/1ps
module rsi_dual_chk (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic a_in,
  input  wire logic b_in,
  output logic      closed_out,
  output logic      open_out,
  output logic      fault_out
);
  ////////////////////////////////////////////////////////////////////////
  // Both contacts must agree; a lone channel is a fault for as long as it lasts
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      closed_out <= 1'b0;
      open_out   <= 1'b1;
      fault_out  <= 1'b0;
    end else begin
      closed_out <= a_in & b_in;
      open_out   <= ~a_in & ~b_in;
      fault_out  <= a_in ^ b_in;
    end
  end
endmodule

// file: sim/rsi_fence_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Customer fence switches and teaching pendant as wired contacts
module rsi_fence_model (
  input  wire logic door_in,
  input  wire logic estop_in,
  input  wire logic mode_in,
  input  wire logic pend_in,
  input  wire logic esw_in,
  input  wire logic stop_in,
  input  wire logic split_door_in,
  input  wire logic split_mode_in,
  output logic      door_a_out,
  output logic      door_b_out,
  output logic      estop_a_out,
  output logic      estop_b_out,
  output logic      mode_a_out,
  output logic      mode_b_out,
  output logic      pend_out,
  output logic      esw_out,
  output logic      stop_out
);
  // Both contacts of a dual switch move together; a split models a broken wire
  assign door_a_out  = door_in;
  assign door_b_out  = door_in ^ split_door_in;
  assign estop_a_out = estop_in;
  assign estop_b_out = estop_in;
  assign mode_a_out  = mode_in;
  assign mode_b_out  = mode_in ^ split_mode_in;
  assign pend_out    = pend_in;
  assign esw_out     = esw_in;
  // Single dedicated stop line, never shared with another contact
  assign stop_out    = stop_in;
endmodule

// file: sim/robot_safety_interlock_test.sv
`timescale 1ns/1ps
module robot_safety_interlock_test;
  import rsi_pkg::*;
  localparam int unsigned STOP_CYC = 8;
  logic         clk_sys = 1'b0;
  logic         resetn  = 1'b0;
  rsi_axi_req_t req     = '0;
  rsi_axi_rsp_t rsp;
  logic         door = 1'b1, estop = 1'b1, mode = 1'b1, pend = 1'b0, esw = 1'b0, stop = 1'b0, sd = 1'b0, sm = 1'b0;
  logic         da, db, ea, eb, ma, mb, pen, sw, sk;
  logic         servo, mstop, rerr, eout, mout, jog, brk, aut, irq;
  int           err_count = 0, checks_done = 0, cyc = 0, exp_st = 3, i;
  int           seed = 32'h1CCE;
  logic [5:0]   exp_stat = 6'h00, exp_mask = 6'h00;
  logic [31:0]  rd, m;
  logic [1:0]   rs;

  rsi_fence_model rsi_fence_model_i (.door_in(door), .estop_in(estop), .mode_in(mode), .pend_in(pend),
    .esw_in(esw), .stop_in(stop), .split_door_in(sd), .split_mode_in(sm), .door_a_out(da), .door_b_out(db),
    .estop_a_out(ea), .estop_b_out(eb), .mode_a_out(ma), .mode_b_out(mb), .pend_out(pen), .esw_out(sw),
    .stop_out(sk));
  rsi_top #(.STOP_RESP_CYC(STOP_CYC)) rsi_top_i (.clk_sys_in(clk_sys), .resetn_in(resetn), .axi_req_in(req),
    .axi_rsp_out(rsp), .special_stop_in(sk), .estop_a_in(ea), .estop_b_in(eb), .door_a_in(da), .door_b_in(db),
    .mode_a_in(ma), .mode_b_in(mb), .pendant_en_in(pen), .enable_sw_in(sw), .servo_on_out(servo),
    .motion_stop_out(mstop), .robot_error_out(rerr), .estop_out(eout), .mode_out(mout), .jog_permit_out(jog),
    .brake_release_out(brk), .auto_permit_out(aut), .irq_out(irq));

  ////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and a hang guard well above the expected run length
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_pin(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t output %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t bus value %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master; upper lanes carry random junk the slave must ignore
  task automatic wr(input logic [3:0] a, input logic [7:0] b, input logic [1:0] er);
    bit          done;
    logic [31:0] r;
    done = 0;
    r = $random(seed);
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {r[31:8], b};
    req.wstrb   <= 4'h1;
    req.bready  <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        done = 1;
        rs = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
    cmp_reg({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] msk, input logic [1:0] er);
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    cmp_reg(rd & msk, e);
    cmp_reg({30'h0, rs}, {30'h0, er});
  endtask

  task automatic ctrl(input int bit_no);
    wr(REG_CTRL, 8'h01 << bit_no, RESP_OK);
  endtask

  // Contacts move after an edge; outputs follow four edges later, eight is margin
  task automatic setp(input logic d, input logic e, input logic md, input logic p, input logic w);
    @(posedge clk_sys);
    door  <= d;
    estop <= e;
    mode  <= md;
    pend  <= p;
    esw   <= w;
    repeat (8) @(posedge clk_sys);
  endtask

  // Registered outputs change on the same edge as the state after a bus write; three edges are margin
  task automatic chk_out;
    repeat (3) @(posedge clk_sys);
    cmp_pin(servo, exp_st == 1 || exp_st == 2);
    cmp_pin(rerr, exp_st == 3);
    cmp_pin(aut, exp_st == 2);
    cmp_pin(irq, |(exp_stat & exp_mask));
    cmp_pin(mout, mode);
    rdc(REG_STATE, exp_st, 32'h3, RESP_OK);
  endtask

  task automatic leave;
    ctrl(CTRL_ALM_RST);
    exp_st = 0;
    wr(REG_STATUS, 8'h3F, RESP_OK);
    exp_stat = 6'h00;
    chk_out();
  endtask

  task automatic go_run;
    ctrl(CTRL_SERVO_ON);
    ctrl(CTRL_START);
    exp_st = 2;
    chk_out();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    // Contacts take four edges to reach the pins after release
    repeat (4) @(posedge clk_sys);
    chk_out();
    cmp_pin(mstop, 1'b1);
    rdc(REG_MASK, 32'h0, 32'hFFFFFFFF, RESP_OK);
    rdc(4'h1, 32'h0, 32'hFFFFFFFF, RESP_ERR);
    wr(REG_STATE, 8'h00, RESP_ERR);
    m = $random(seed);
    wr(REG_MASK, m[7:0], RESP_OK);
    rdc(REG_MASK, {26'h0, m[5:0]}, 32'hFFFFFFFF, RESP_OK);
    exp_mask = 6'h3E;
    wr(REG_MASK, 8'h3E, RESP_OK);
    leave();
    go_run();
    // Door opens mid-run; its event is masked out at first
    setp(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    exp_st = 3;
    exp_stat = 6'h01;
    chk_out();
    rdc(REG_STATUS, 32'h1, 32'hFFFFFFFF, RESP_OK);
    exp_mask = 6'h3F;
    wr(REG_MASK, 8'h3F, RESP_OK);
    chk_out();
    ctrl(CTRL_SERVO_ON);
    setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    ctrl(CTRL_START);
    chk_out();
    leave();
    go_run();
    // Special stop must halt quickly, and block a start while held
    @(posedge clk_sys);
    stop <= 1'b1;
    for (i = 0; i < 6 && mstop !== 1'b1; i++) @(posedge clk_sys);
    cmp_pin(mstop, 1'b1);
    exp_st = 1;
    exp_stat = 6'h04;
    ctrl(CTRL_START);
    chk_out();
    @(posedge clk_sys);
    stop <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wr(REG_STATUS, 8'h3F, RESP_OK);
    exp_stat = 6'h00;
    ctrl(CTRL_START);
    exp_st = 2;
    chk_out();
    cmp_pin(mstop, 1'b0);
    // Emergency stop opens; no servo-off request follows, the block acts alone
    setp(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    exp_st = 3;
    exp_stat = 6'h02;
    chk_out();
    cmp_pin(eout, 1'b0);
    setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    leave();
    cmp_pin(eout, 1'b1);
    // One broken door channel, then one broken mode channel
    @(posedge clk_sys);
    sd <= 1'b1;
    setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    exp_st = 3;
    exp_stat = 6'h08;
    chk_out();
    @(posedge clk_sys);
    sd <= 1'b0;
    sm <= 1'b1;
    setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    rdc(REG_STATUS, 32'h18, 32'hFFFFFFFF, RESP_OK);
    @(posedge clk_sys);
    sm <= 1'b0;
    setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    leave();
    // Pendant on in automatic mode refuses servo on
    setp(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    ctrl(CTRL_SERVO_ON);
    chk_out();
    cmp_pin(jog, 1'b0);
    // Teaching with the door open
    setp(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    ctrl(CTRL_SERVO_ON);
    exp_st = 1;
    chk_out();
    // Jog is granted only once the servo is on
    cmp_pin(jog, 1'b1);
    setp(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    exp_st = 0;
    chk_out();
    cmp_pin(jog, 1'b0);
    setp(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    ctrl(CTRL_BRAKE);
    repeat (3) @(posedge clk_sys);
    cmp_pin(brk, 1'b1);
    setp(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    cmp_pin(brk, 1'b0);
    // Back to automatic with the door closed, send an alarm reset from idle, then run again
    setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    leave();
    go_run();
    // Servo-off request drops a running robot to idle
    ctrl(CTRL_SERVO_OFF);
    exp_st = 0;
    chk_out();
    go_run();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    exp_st = 3;
    exp_mask = 6'h00;
    chk_out();
    report_and_stop();
  end
endmodule
